// file: inc/adcsc_map.svh
`ifndef ADCSC_MAP_SVH
`define ADCSC_MAP_SVH
`define ADCSC_ADDR_W 12
`define ADCSC_CSR_IDX 12'h0e8
`define ADCSC_TRG_IDX 12'h0e9
`define ADCSC_CSR_ADDR (`ADCSC_CSR_IDX << 2)
`define ADCSC_TRG_ADDR (`ADCSC_TRG_IDX << 2)
`define ADCSC_EVT_ADDR 12'h3b0
`define ADCSC_MSK_ADDR 12'h3b4
`define ADCSC_FLAG_BIT 7
`define ADCSC_IE_BIT 6
`define ADCSC_START_BIT 5
`define ADCSC_SCAN_BIT 4
`define ADCSC_CKS_BIT 3
`define ADCSC_CH_HI 2
`define ADCSC_CH_LO 0
`define ADCSC_EXTERNAL_TRIGGER_ENABLE_BIT 7
`define ADCSC_TRG_RSVD 7'h7f
`define ADCSC_EVT_W 2
`define ADCSC_EVT_END 0
`define ADCSC_EVT_TRG 1
`define ADCSC_SLOW_STATES 266
`define ADCSC_FAST_STATES 134
`define ADCSC_CYC_PER_STATE 1
`define ADCSC_TMR_W 9
`define ADCSC_SLOW_LOAD (9'(`ADCSC_SLOW_STATES * `ADCSC_CYC_PER_STATE - 1))
`define ADCSC_FAST_LOAD (9'(`ADCSC_FAST_STATES * `ADCSC_CYC_PER_STATE - 1))
`define ADCSC_RESP_OKAY 2'h0
`define ADCSC_RESP_SLVERR 2'h2
`define ADCSC_PIN_IDLE 1'h1
`endif

// file: inc/adcsc_pkg.sv
`include "adcsc_map.svh"
`default_nettype none
package adcsc_pkg;
   typedef logic [`ADCSC_ADDR_W-1:0] adcsc_addr_type;
   typedef logic [2:0] adcsc_chan_type;
   typedef logic [`ADCSC_EVT_W-1:0] adcsc_evt_type;
   typedef struct packed {
      logic int_en;
      logic start;
      logic scan;
      logic conversion_time_select;
      adcsc_chan_type ch;
   } adcsc_ctrl_type;
   typedef enum {REG_CSR, REG_TRG, REG_EVT, REG_MSK, REG_NONE} adcsc_reg_type;
   typedef enum {ST_IDLE, ST_CONV} adcsc_state_type;
endpackage
`default_nettype wire

// file: hdl/adcsc_sync.sv
`include "adcsc_map.svh"
`default_nettype none
module adcsc_sync (
   input wire logic clock,
   input wire logic rst,
   input wire logic pin,
   output logic fall
);
   logic meta;
   logic stable;
   logic prev;

   // two-stage synchroniser, then edge detect on the settled level
   always_ff @(posedge clock) begin
      if (rst) begin
         meta <= `ADCSC_PIN_IDLE;
         stable <= `ADCSC_PIN_IDLE;
         prev <= `ADCSC_PIN_IDLE;
      end else begin
         meta <= pin;
         stable <= meta;
         prev <= stable;
      end
   end

   assign fall = prev & ~stable;
endmodule
`default_nettype wire

// file: hdl/adcsc_timer.sv
`include "adcsc_map.svh"
`default_nettype none
module adcsc_timer (
   input wire logic clock,
   input wire logic rst,
   input wire logic load,
   input wire logic abort,
   input wire logic fast,
   output logic done
);
   logic [`ADCSC_TMR_W-1:0] count;
   logic busy;

   // conversion time counter, done lands the set number of cycles after load
   always_ff @(posedge clock) begin
      if (rst) begin
         count <= '0;
         busy <= 1'b0;
      end else if (abort) begin
         busy <= 1'b0;
      end else if (load) begin
         count <= fast ? `ADCSC_FAST_LOAD : `ADCSC_SLOW_LOAD;
         busy <= 1'b1;
      end else if (busy) begin
         if (count == '0) begin
            busy <= 1'b0;
         end else begin
            count <= count - 1'b1;
         end
      end
   end

   assign done = busy && (count == '0) && !abort;
endmodule
`default_nettype wire

// file: hdl/adcsc_top.sv
`include "adcsc_map.svh"
`default_nettype none
module adcsc_top (
   input wire logic CLOCK,
   input wire logic RST,
   input wire adcsc_pkg::adcsc_addr_type S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire adcsc_pkg::adcsc_addr_type S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic EXTERNAL_TRIGGER_INPUT,
   input wire logic STANDBY,
   output logic CONV_START,
   output adcsc_pkg::adcsc_chan_type CONV_CHANNEL,
   output logic CONV_BUSY,
   output logic CONV_END,
   output logic END_IRQ,
   output logic IRQ
);
   import adcsc_pkg::*;

   adcsc_ctrl_type csr;
   logic end_flag;
   logic flag_read;
   logic trg_en;
   adcsc_evt_type evt_status;
   adcsc_evt_type evt_mask;
   adcsc_state_type state;

   logic aw_held;
   logic w_held;
   adcsc_addr_type aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   adcsc_reg_type wr_reg;
   logic wr_csr;
   logic wr_trg;
   logic wr_evt;
   logic wr_msk;
   logic ar_hs;
   adcsc_reg_type rd_reg;

   logic trig_fall;
   logic trig_go;
   logic conv_done;
   logic fin;
   logic last;
   logic set_end;
   logic single_done;
   logic flag_clr;
   logic abort;
   adcsc_evt_type next_evt;

   function automatic adcsc_reg_type reg_decode(adcsc_addr_type a);
      adcsc_addr_type w;
      w = {a[`ADCSC_ADDR_W-1:2], 2'h0};
      if (w == `ADCSC_CSR_ADDR) begin
         reg_decode = REG_CSR;
      end else if (w == `ADCSC_TRG_ADDR) begin
         reg_decode = REG_TRG;
      end else if (w == `ADCSC_EVT_ADDR) begin
         reg_decode = REG_EVT;
      end else if (w == `ADCSC_MSK_ADDR) begin
         reg_decode = REG_MSK;
      end else begin
         reg_decode = REG_NONE;
      end
   endfunction

   // first input of the selection
   function automatic adcsc_chan_type first_chan(adcsc_ctrl_type c);
      first_chan = c.scan ? {c.ch[2], 2'h0} : c.ch;
   endfunction

   // write address channel
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         S_AXI_AWREADY <= 1'b0;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_held <= 1'b1;
         aw_addr <= S_AXI_AWADDR;
         S_AXI_AWREADY <= 1'b0;
      end else if (wr_go) begin
         aw_held <= 1'b0;
         S_AXI_AWREADY <= 1'b1;
      end else if (!aw_held) begin
         S_AXI_AWREADY <= 1'b1;
      end
   end

   // write data channel
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         S_AXI_WREADY <= 1'b0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_held <= 1'b1;
         w_data <= S_AXI_WDATA;
         w_strb <= S_AXI_WSTRB;
         S_AXI_WREADY <= 1'b0;
      end else if (wr_go) begin
         w_held <= 1'b0;
         S_AXI_WREADY <= 1'b1;
      end else if (!w_held) begin
         S_AXI_WREADY <= 1'b1;
      end
   end

   assign wr_go = aw_held && w_held && !S_AXI_BVALID;
   assign wr_reg = reg_decode(aw_addr);
   assign wr_csr = wr_go && (wr_reg == REG_CSR) && w_strb[0];
   assign wr_trg = wr_go && (wr_reg == REG_TRG) && w_strb[0];
   assign wr_evt = wr_go && (wr_reg == REG_EVT) && w_strb[0];
   assign wr_msk = wr_go && (wr_reg == REG_MSK) && w_strb[0];

   // write response
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `ADCSC_RESP_OKAY;
      end else if (wr_go) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= (wr_reg == REG_NONE) ? `ADCSC_RESP_SLVERR : `ADCSC_RESP_OKAY;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // read channel
   assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
   assign rd_reg = reg_decode(S_AXI_ARADDR);

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= '0;
         S_AXI_RRESP <= `ADCSC_RESP_OKAY;
      end else if (ar_hs) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP <= `ADCSC_RESP_OKAY;
         case (rd_reg)
            REG_CSR: S_AXI_RDATA <= {24'h0, end_flag, csr.int_en, csr.start, csr.scan,
                                     csr.conversion_time_select, csr.ch};
            REG_TRG: S_AXI_RDATA <= {24'h0, trg_en, `ADCSC_TRG_RSVD};
            REG_EVT: S_AXI_RDATA <= {30'h0, evt_status};
            REG_MSK: S_AXI_RDATA <= {30'h0, evt_mask};
            default: begin
               S_AXI_RDATA <= '0;
               S_AXI_RRESP <= `ADCSC_RESP_SLVERR;
            end
         endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end else if (!S_AXI_RVALID) begin
         S_AXI_ARREADY <= 1'b1;
      end
   end

   // external trigger pin
   adcsc_sync u_sync (
      .clock(CLOCK),
      .rst(RST),
      .pin(EXTERNAL_TRIGGER_INPUT),
      .fall(trig_fall)
   );

   assign trig_go = trig_fall && trg_en && !csr.start && !STANDBY;

   // trigger control byte
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         trg_en <= 1'b0;
      end else if (wr_trg) begin
         trg_en <= w_data[`ADCSC_EXTERNAL_TRIGGER_ENABLE_BIT];
      end
   end

   // control fields and start bit
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         csr <= '0;
      end else begin
         if (wr_csr) begin
            csr.int_en <= w_data[`ADCSC_IE_BIT];
            csr.start <= w_data[`ADCSC_START_BIT];
            csr.scan <= w_data[`ADCSC_SCAN_BIT];
            csr.conversion_time_select <= w_data[`ADCSC_CKS_BIT];
            csr.ch <= w_data[`ADCSC_CH_HI:`ADCSC_CH_LO];
         end
         if (trig_go) begin
            csr.start <= 1'b1;
         end
         if (single_done) begin
            csr.start <= 1'b0;
         end
         if (STANDBY) begin
            csr.start <= 1'b0;
         end
      end
   end

   // conversion sequencing
   assign last = !csr.scan || (CONV_CHANNEL[1:0] == csr.ch[1:0]);
   assign abort = (state == ST_CONV) && (!csr.start || STANDBY);
   assign fin = (state == ST_CONV) && !abort && conv_done;
   assign set_end = fin && last;
   assign single_done = fin && !csr.scan;

   adcsc_timer u_timer (
      .clock(CLOCK),
      .rst(RST),
      .load(CONV_START),
      .abort(abort),
      .fast(csr.conversion_time_select),
      .done(conv_done)
   );

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state <= ST_IDLE;
         CONV_START <= 1'b0;
         CONV_CHANNEL <= '0;
         CONV_BUSY <= 1'b0;
      end else begin
         CONV_START <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (csr.start && !STANDBY) begin
                  state <= ST_CONV;
                  CONV_CHANNEL <= first_chan(csr);
                  CONV_START <= 1'b1;
                  CONV_BUSY <= 1'b1;
               end
            end
            ST_CONV: begin
               if (abort) begin
                  state <= ST_IDLE;
                  CONV_BUSY <= 1'b0;
               end else if (conv_done) begin
                  if (!csr.scan) begin
                     state <= ST_IDLE;
                     CONV_BUSY <= 1'b0;
                  end else begin
                     CONV_CHANNEL <= last ? first_chan(csr) : CONV_CHANNEL + 3'h1;
                     CONV_START <= 1'b1;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
               CONV_BUSY <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         CONV_END <= 1'b0;
      end else begin
         CONV_END <= fin;
      end
   end

   // end flag, cleared by read-while-set then write zero; a set wins
   assign flag_clr = wr_csr && !w_data[`ADCSC_FLAG_BIT] && flag_read && end_flag;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         end_flag <= 1'b0;
         flag_read <= 1'b0;
      end else begin
         if (ar_hs && (rd_reg == REG_CSR) && end_flag) begin
            flag_read <= 1'b1;
         end
         if (flag_clr) begin
            end_flag <= 1'b0;
            flag_read <= 1'b0;
         end
         if (set_end) begin
            end_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         END_IRQ <= 1'b0;
      end else begin
         END_IRQ <= end_flag && csr.int_en;
      end
   end

   // event status, write one to clear, set wins
   always_comb begin
      next_evt = evt_status;
      if (wr_evt) begin
         next_evt = next_evt & ~w_data[`ADCSC_EVT_W-1:0];
      end
      next_evt[`ADCSC_EVT_END] = next_evt[`ADCSC_EVT_END] | set_end;
      next_evt[`ADCSC_EVT_TRG] = next_evt[`ADCSC_EVT_TRG] | trig_go;
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         evt_status <= '0;
         evt_mask <= '0;
         IRQ <= 1'b0;
      end else begin
         evt_status <= next_evt;
         if (wr_msk) begin
            evt_mask <= w_data[`ADCSC_EVT_W-1:0];
         end
         IRQ <= |(evt_status & evt_mask);
      end
   end

   // checks
   logic [`ADCSC_TMR_W:0] a_cnt;
   logic a_cks;
   localparam logic [`ADCSC_TMR_W:0] a_fast_cyc = 10'(`ADCSC_FAST_STATES * `ADCSC_CYC_PER_STATE);
   localparam logic [`ADCSC_TMR_W:0] a_slow_cyc = 10'(`ADCSC_SLOW_STATES * `ADCSC_CYC_PER_STATE);

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         a_cnt <= '0;
         a_cks <= 1'b0;
      end else if (CONV_START) begin
         a_cnt <= 10'h001;
         a_cks <= csr.conversion_time_select;
      end else begin
         a_cnt <= a_cnt + 10'h001;
      end
   end

   default clocking a_clk @(posedge CLOCK);
   endclocking
   default disable iff (RST);

   a_conv_time: assert property (conv_done |-> a_cnt == (a_cks ? a_fast_cyc : a_slow_cyc))
      else $error("conversion time does not match clock select");
   a_trig_ignored: assert property ((trig_fall && !trg_en && !csr.start && !wr_csr) |=> ##1 !CONV_START)
      else $error("disabled trigger started a conversion");
   a_trig_start: assert property ((trig_fall && trg_en && state == ST_IDLE && !csr.start && !STANDBY
      && !wr_csr) |=> ##1 CONV_START)
      else $error("enabled trigger edge did not start conversion");
   a_single_chan: assert property ((state == ST_IDLE && csr.start && !csr.scan && !STANDBY)
      |=> CONV_START && CONV_CHANNEL == $past(csr.ch))
      else $error("single mode converted the wrong input");
   a_scan_group: assert property ((CONV_START && $past(csr.scan)) |-> CONV_CHANNEL[2] == $past(csr.ch[2])
      && CONV_CHANNEL[1:0] <= $past(csr.ch[1:0]))
      else $error("scan left its group");
   a_stop_held: assert property (!csr.start |=> !CONV_START)
      else $error("conversion began with start clear");
   a_single_clear: assert property (single_done |=> !csr.start && !CONV_BUSY)
      else $error("start not cleared after single conversion");
   a_scan_keeps: assert property ((fin && csr.scan && !STANDBY && !wr_csr) |=> csr.start && CONV_START)
      else $error("scan stopped by itself");
   a_standby_stop: assert property (STANDBY |=> !csr.start)
      else $error("standby did not clear start");
   a_flag_set: assert property (set_end |=> end_flag)
      else $error("end flag not set");
   a_flag_hold: assert property ((end_flag && !flag_read) |=> end_flag)
      else $error("end flag cleared without prior read");
   a_flag_one: assert property ((end_flag && wr_csr && w_data[`ADCSC_FLAG_BIT]) |=> end_flag)
      else $error("writing one cleared the end flag");
   a_end_irq: assert property ((end_flag && csr.int_en) |=> END_IRQ)
      else $error("end interrupt missing");
   a_end_mask: assert property (!csr.int_en |=> !END_IRQ)
      else $error("end interrupt not suppressed");
endmodule
`default_nettype wire

// file: test/adcsc_analog_model.sv
`include "adcsc_map.svh"
`default_nettype none
module adcsc_analog_model (
   input wire logic clock,
   input wire logic conv_start,
   input wire adcsc_pkg::adcsc_chan_type conv_channel,
   output logic trigger_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   import adcsc_pkg::*;
   int cyc = 0;
   int last = 0;
   int spacing = 0;
   int starts = 0;
   adcsc_chan_type chans[$];
   initial trigger_pin = `ADCSC_PIN_IDLE;
   // notes every conversion begun and the gap from the one before
   always @(posedge clock) begin
      cyc++;
      if (conv_start === 1'b1) begin
         spacing = cyc - last;
         last = cyc;
         starts++;
         chans.push_back(conv_channel);
      end
   end
   // trigger pin idles high, a short low pulse gives one falling edge
   task automatic fire();
      @(posedge clock);
      trigger_pin <= 1'b0;
      repeat (4) @(posedge clock);
      trigger_pin <= 1'b1;
   endtask
endmodule
`default_nettype wire

// file: test/tb_adc_sequence_control.sv
`include "adcsc_map.svh"
`default_nettype none
module tb_adc_sequence_control;
   timeunit 1ns;
   timeprecision 100ps;
   import adcsc_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   adcsc_addr_type awaddr = '0;
   adcsc_addr_type araddr = '0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic standby = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, conv_start, conv_busy, conv_end, end_irq, irq, trig;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   adcsc_chan_type conv_channel;
   int errors = 0;
   int checked = 0;
   int n;
   logic [2:0] scan_exp[4] = '{3'h4, 3'h5, 3'h6, 3'h4};

   always #5 clock = ~clock;

   adcsc_top dut (
      .CLOCK(clock), .RST(rst),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .EXTERNAL_TRIGGER_INPUT(trig), .STANDBY(standby),
      .CONV_START(conv_start), .CONV_CHANNEL(conv_channel), .CONV_BUSY(conv_busy),
      .CONV_END(conv_end), .END_IRQ(end_irq), .IRQ(irq)
   );

   adcsc_analog_model model (
      .clock(clock), .conv_start(conv_start), .conv_channel(conv_channel), .trigger_pin(trig)
   );

   task automatic check_value(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic axi_write(input adcsc_addr_type a, input logic [7:0] d, output logic [1:0] r);
      @(posedge clock);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input adcsc_addr_type a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic wr(input adcsc_addr_type a, input logic [7:0] d);
      axi_write(a, d, resp);
      check_value({30'h0, resp}, {30'h0, `ADCSC_RESP_OKAY});
   endtask

   task automatic rd_chk(input adcsc_addr_type a, input logic [7:0] exp);
      axi_read(a, rd, resp);
      check_value({30'h0, resp}, {30'h0, `ADCSC_RESP_OKAY});
      check_value(rd, {24'h000000, exp});
   endtask

   task automatic wait_end();
      do @(posedge clock); while (conv_end !== 1'b1);
   endtask

   task automatic print_verdict();
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      print_verdict();
   end

   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      // reset values and reserved bits
      rd_chk(`ADCSC_CSR_ADDR, 8'h00);
      rd_chk(`ADCSC_TRG_ADDR, 8'h7f);
      wr(`ADCSC_TRG_ADDR, 8'h00);
      rd_chk(`ADCSC_TRG_ADDR, 8'h7f);
      axi_read(12'h100, rd, resp);
      check_value({rd[29:0], resp}, {30'h0, `ADCSC_RESP_SLVERR});
      axi_write(12'h100, 8'hff, resp);
      check_value({30'h0, resp}, {30'h0, `ADCSC_RESP_SLVERR});
      // single conversion of input 2, slow timing
      wr(`ADCSC_CSR_ADDR, 8'h22);
      wait_end();
      check_value({29'h0, model.chans[$]}, 32'h2);
      check_value({31'h0, conv_busy}, 32'h0);
      rd_chk(`ADCSC_CSR_ADDR, 8'h82);
      wr(`ADCSC_CSR_ADDR, 8'h00);
      // scan group 1, three inputs, fast timing
      model.chans.delete();
      wr(`ADCSC_CSR_ADDR, 8'h3e);
      wait_end();
      rd_chk(`ADCSC_CSR_ADDR, 8'h3e);
      repeat (3) wait_end();
      for (int i = 0; i < 4; i++) begin
         check_value({29'h0, model.chans[i]}, {29'h0, scan_exp[i]});
      end
      // one restart cycle between done and the next start in scan
      check_value(model.spacing, `ADCSC_FAST_STATES * `ADCSC_CYC_PER_STATE + 1);
      rd_chk(`ADCSC_CSR_ADDR, 8'hbe);
      wr(`ADCSC_CSR_ADDR, 8'h1e);
      n = model.starts;
      repeat (300) @(posedge clock);
      check_value(model.starts, n);
      check_value({31'h0, conv_busy}, 32'h0);
      // scan of input 0 alone, slow timing, stopped by standby
      model.chans.delete();
      wr(`ADCSC_CSR_ADDR, 8'h30);
      repeat (2) wait_end();
      check_value({29'h0, model.chans[1]}, 32'h0);
      check_value(model.spacing, `ADCSC_SLOW_STATES * `ADCSC_CYC_PER_STATE + 1);
      check_value({31'h0, end_irq}, 32'h0);
      standby <= 1'b1;
      repeat (2) @(posedge clock);
      standby <= 1'b0;
      n = model.starts;
      repeat (300) @(posedge clock);
      check_value(model.starts, n);
      check_value({31'h0, conv_busy}, 32'h0);
      // end flag survives a clear without a prior read, and a write of one
      wr(`ADCSC_CSR_ADDR, 8'h40);
      repeat (3) @(posedge clock);
      check_value({31'h0, end_irq}, 32'h1);
      rd_chk(`ADCSC_CSR_ADDR, 8'hc0);
      wr(`ADCSC_CSR_ADDR, 8'hc0);
      rd_chk(`ADCSC_CSR_ADDR, 8'hc0);
      wr(`ADCSC_CSR_ADDR, 8'h40);
      rd_chk(`ADCSC_CSR_ADDR, 8'h40);
      repeat (3) @(posedge clock);
      check_value({31'h0, end_irq}, 32'h0);
      // external trigger, disabled then enabled
      wr(`ADCSC_CSR_ADDR, 8'h05);
      n = model.starts;
      model.fire();
      repeat (20) @(posedge clock);
      check_value(model.starts, n);
      wr(`ADCSC_TRG_ADDR, 8'h80);
      rd_chk(`ADCSC_TRG_ADDR, 8'hff);
      model.fire();
      wait_end();
      check_value({29'h0, model.chans[$]}, 32'h5);
      rd_chk(`ADCSC_CSR_ADDR, 8'h85);
      // event status, mask and interrupt line
      rd_chk(`ADCSC_EVT_ADDR, 8'h03);
      check_value({31'h0, irq}, 32'h0);
      wr(`ADCSC_MSK_ADDR, 8'h02);
      repeat (3) @(posedge clock);
      check_value({31'h0, irq}, 32'h1);
      wr(`ADCSC_EVT_ADDR, 8'h02);
      repeat (3) @(posedge clock);
      check_value({31'h0, irq}, 32'h0);
      rd_chk(`ADCSC_EVT_ADDR, 8'h01);
      wr(`ADCSC_MSK_ADDR, 8'h01);
      repeat (3) @(posedge clock);
      check_value({31'h0, irq}, 32'h1);
      wr(`ADCSC_EVT_ADDR, 8'h01);
      repeat (3) @(posedge clock);
      check_value({31'h0, irq}, 32'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
